// File: dv/scirq_asserts.sv
// Port-level assertion checker for the serial-two interrupt block
`timescale 1ns/1ps
`default_nettype none
module scirq_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Steps of a bus access and of a quiet spell with no register writes
    sequence access_s; psel && penable && !pready; endsequence
    sequence quiet_s; !(psel && pwrite) [*3]; endsequence
    answer_time_a: assert property (access_s |=> pready) else $error("answer late");
    answer_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    answer_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    // Read data is only driven in the answer cycle
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero");
    upper_zero_a: assert property (pready |-> prdata[31:13] == 19'h00000)
        else $error("upper bits not zero");
    err_answer_a: assert property (pslverr |-> pready) else $error("pslverr stray");
    err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read data");
    // Without writes, pending and enable cannot drop, so irq must hold
    irq_sticky_a: assert property (quiet_s ##0 irq |=> irq)
        else $error("irq dropped");
endmodule : scirq_asserts
bind scirq_top scirq_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
`default_nettype wire

// File: dv/scirq_intc_model.sv
// Interrupt controller model: counts rising edges of the request line
`timescale 1ns/1ps
`default_nettype none
module scirq_intc_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       irq,
    output logic [7:0]      irq_count
);
    logic irq_q;
    // Edge count lets the bench see a missed or doubled request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q     <= 1'h0;
            irq_count <= 8'h00;
        end else begin
            irq_q <= irq;
            if (irq && !irq_q) irq_count <= irq_count + 8'h01;
        end
    end
endmodule : scirq_intc_model
`default_nettype wire

// File: dv/scirq_top_tb.sv
// Self-checking testbench for the serial-two interrupt block
`timescale 1ns/1ps
`default_nettype none
module scirq_top_tb;
    localparam logic [15:0] IA = scirq_pkg::IDX_RX_ERR_A;
    localparam logic [15:0] IB = scirq_pkg::IDX_RX_ERR_B;
    localparam logic [15:0] IP = scirq_pkg::IDX_IRQ_PEND;
    localparam logic [15:0] IE = scirq_pkg::IDX_IRQ_ENABLE;
    localparam logic [13:0] NE = 14'h0000;
    logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic                     lda, ldb, dmarst;
    logic [3:0]               strb;
    logic [17:0]              paddr;
    logic [31:0]              pwdata, prdata, rd;
    logic [12:0]              ev;
    logic [7:0]               irq_count;
    scirq_pkg::scirq_rx_err_t erra, errb;
    int                       n_mismatch, samples_checked;
    initial pclk = 1'h0;
    always #50 pclk = ~pclk;
    scirq_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_err_a(erra), .rx_err_b(errb),
        .rx_buf_a_evt({ev[9], lda}), .rx_buf_b_evt({ev[10], ldb}), .rx_dma_reset(dmarst),
        .tx_buffer_b_unloaded_event(ev[12]), .tx_buffer_a_unloaded_event(ev[11]),
        .i2c_nack_received_event(ev[8]), .i2c_command_done_event(ev[7]),
        .i2c_transmit_done_event(ev[6]), .i2c_receive_done_event(ev[5]),
        .transmit_underrun_event(ev[4]), .receive_overrun_event(ev[3]),
        .transmitter_idle_event(ev[2]), .transmit_space_free_event(ev[1]),
        .receive_data_available_event(ev[0]), .irq(irq));
    scirq_intc_model i_intc (.pclk(pclk), .presetn(presetn), .irq(irq), .irq_count(irq_count));
    // One APB transfer; waits on pready, watchdog cuts a hang
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        @(posedge pclk);
        psel <= 1'h1; pwrite <= w; paddr <= {idx, 2'h0}; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        d = prdata; e = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'h1, idx, d, rd, er);
        chk({31'h0, er}, 32'h0);
    endtask : wr
    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 32'h0, rd, er);
        chk({er, rd[30:0]}, exp);
    endtask : rdchk
    // One-cycle pulse on the event, load, error and DMA reset inputs
    task automatic stim(input logic [12:0] v, input logic [1:0] ld, input logic [13:0] a,
                        input logic [13:0] b, input logic r);
        @(posedge pclk);
        ev <= v; {lda, ldb} <= ld; erra <= a; errb <= b; dmarst <= r;
        @(posedge pclk);
        ev <= 13'h0000; {lda, ldb} <= 2'h0; erra <= NE; errb <= NE; dmarst <= 1'h0;
    endtask : stim
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ev, lda, ldb, dmarst} = '0;
        erra = NE; errb = NE; presetn = 1'h0;
        strb = 4'hF;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        rdchk(IA, 32'h0); rdchk(IB, 32'h0); rdchk(IP, 32'h0); rdchk(IE, 32'h0);
        apb(1'h0, 16'h0001, 32'h0, rd, er);
        chk({er, rd[30:0]}, 32'h8000_0000);
        stim(13'h0001, 2'h0, NE, NE, 1'h0);
        rdchk(IP, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(IE, 32'hFFFF_FFFF);
        rdchk(IE, 32'h1FFF);
        chk({31'h0, irq}, 32'h1);
        for (int i = 1; i < 13; i++) begin
            stim(13'h0001 << i, 2'h0, NE, NE, 1'h0);
            rdchk(IP, (32'h2 << i) - 32'h1);
        end
        wr(IP, 32'h1FFF);
        rdchk(IP, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Event lands on the very edge that clears it
        fork
            wr(IP, 32'h1);
            begin
                repeat (2) @(posedge pclk);
                ev <= 13'h0001;
                @(posedge pclk);
                ev <= 13'h0000;
            end
        join
        rdchk(IP, 32'h1);
        wr(IP, 32'h1);
        stim(13'h0000, 2'h3, NE, NE, 1'h0);
        stim(13'h0000, 2'h0, 14'h2123, NE, 1'h0);
        rdchk(IA, 32'h0123);
        rdchk(IB, 32'h0);
        stim(13'h0000, 2'h0, 14'h3FFF, 14'h2AAA, 1'h0);
        rdchk(IA, 32'h0123);
        rdchk(IB, 32'h0AAA);
        stim(13'h0000, 2'h2, 14'h2777, NE, 1'h0);
        rdchk(IA, 32'h0123);
        stim(13'h0200, 2'h0, NE, NE, 1'h0);
        stim(13'h0000, 2'h2, NE, NE, 1'h0);
        rdchk(IA, 32'h0);
        stim(13'h0000, 2'h0, 14'h3FFF, NE, 1'h0);
        rdchk(IA, 32'h1FFF);
        stim(13'h0000, 2'h0, NE, NE, 1'h1);
        rdchk(IA, 32'h0); rdchk(IB, 32'h0);
        stim(13'h0000, 2'h0, NE, 14'h2005, 1'h0);
        rdchk(IB, 32'h0005);
        chk({24'h0, irq_count}, 32'h3);
        // A write with neither low lane must not touch enable; then single enable bits gate irq
        strb <= 4'h4;
        wr(IE, 32'h0000_0000);
        strb <= 4'hF;
        rdchk(IE, 32'h1FFF);
        wr(IE, 32'h0000_1000);
        stim(13'h0800, 2'h0, NE, NE, 1'h0);
        rdchk(IP, 32'h0A00);
        chk({31'h0, irq}, 32'h0);
        stim(13'h1000, 2'h0, NE, NE, 1'h0);
        rdchk(IE, 32'h1000);
        chk({31'h0, irq}, 32'h1);
        wr(IE, 32'h0000_0100);
        stim(13'h0100, 2'h0, NE, NE, 1'h0);
        rdchk(IP, 32'h1B00);
        chk({31'h0, irq}, 32'h1);
        chk({24'h0, irq_count}, 32'h5);
        results();
    end
endmodule : scirq_top_tb
`default_nettype wire

// File: rtl/scirq_err_log.sv
// First-error offset logger for one receive DMA buffer
`timescale 1ns/1ps
`default_nettype none

module scirq_err_log (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire scirq_pkg::scirq_rx_err_t err_in,
    input  wire scirq_pkg::scirq_buf_evt_t buf_evt,
    input  wire logic                    dma_reset,
    output logic [12:0]                  offset_q
);

    logic captured_q;  // One error already held
    logic unloaded_q;  // Unload seen, waiting for reload to re-arm

    // Capture only the first error; unload then reload, or DMA reset, re-arms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_q   <= scirq_pkg::RST_OFFSET;
            captured_q <= 1'b0;
            unloaded_q <= 1'b0;
        end else if (dma_reset) begin
            offset_q   <= scirq_pkg::RST_OFFSET;
            captured_q <= 1'b0;
            unloaded_q <= 1'b0;
        end else if (buf_evt.load && (unloaded_q || buf_evt.unload)) begin
            // Fresh buffer reads zero until its own first error
            offset_q   <= scirq_pkg::RST_OFFSET;
            captured_q <= 1'b0;
            unloaded_q <= 1'b0;
        end else begin
            if (buf_evt.unload) begin
                unloaded_q <= 1'b1;
            end
            if (err_in.err && !captured_q) begin
                offset_q   <= err_in.offset;
                captured_q <= 1'b1;
            end
        end
    end

endmodule : scirq_err_log

`default_nettype wire

// File: rtl/scirq_pkg.sv
// Package: register map, field layout and carrier types for the serial-two interrupt block
package scirq_pkg;

    // Printed offsets are not all multiples of four, so they are kept as indices
    localparam logic [15:0] IDX_RX_ERR_A   = 16'h441A;
    localparam logic [15:0] IDX_RX_ERR_B   = 16'h441C;
    localparam logic [15:0] IDX_IRQ_PEND   = 16'h460E;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'h4626;

    localparam int          ADDR_W         = 18;
    localparam int          OFFS_W         = 13;
    localparam int          EVT_W          = 13;

    localparam logic [12:0] RST_OFFSET     = 13'h0000;
    localparam logic [12:0] RST_EVT        = 13'h0000;
    localparam logic [31:0] RST_RDATA      = 32'h0000_0000;

    // Event bit positions, shared by the enable and pending registers
    localparam int BIT_TX_B_UNLOADED = 12;
    localparam int BIT_TX_A_UNLOADED = 11;
    localparam int BIT_RX_B_UNLOADED = 10;
    localparam int BIT_RX_A_UNLOADED = 9;
    localparam int BIT_I2C_NACK      = 8;
    localparam int BIT_I2C_CMD_DONE  = 7;
    localparam int BIT_I2C_TX_DONE   = 6;
    localparam int BIT_I2C_RX_DONE   = 5;
    localparam int BIT_TX_UNDERRUN   = 4;
    localparam int BIT_RX_OVERRUN    = 3;
    localparam int BIT_TX_IDLE       = 2;
    localparam int BIT_TX_FREE       = 1;
    localparam int BIT_RX_AVAILABLE  = 0;

    // Error report from the receive DMA for one buffer
    typedef struct packed {
        logic        err;
        logic [12:0] offset;
    } scirq_rx_err_t;

    // Per-buffer lifecycle strobes from the receive DMA
    typedef struct packed {
        logic unload;
        logic load;
    } scirq_buf_evt_t;

endpackage : scirq_pkg

// File: rtl/scirq_top.sv
// Serial-two interrupt enable/pending registers and receive error log behind APB
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Read-only 13-bit offset of first bad byte in receive buffer A.
// - Read-only 13-bit offset of first bad byte in receive buffer B.
// - An offset register reads zero until an error is logged.
// - After the first capture, later errors in that buffer change nothing.
// - Logging re-arms only on unload then reload, or receive DMA reset.
// - Enable bits 12..9 gate tx B, tx A, rx B, rx A unloaded.
// - Enable bits 8..5 gate nack, command done, tx done, rx done.
// - Enable bits 4..0 gate underrun, overrun, idle, free, data available.
// - Pending bits 12..9 latch the four buffer unloaded events.
// - Pending bits 8..5 latch the four I2C events.
// - Pending bits 4..0 latch the five buffer condition events.
module scirq_top #(
    parameter int ADDR_W = scirq_pkg::ADDR_W
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire scirq_pkg::scirq_rx_err_t  rx_err_a,
    input  wire scirq_pkg::scirq_rx_err_t  rx_err_b,
    input  wire scirq_pkg::scirq_buf_evt_t rx_buf_a_evt,
    input  wire scirq_pkg::scirq_buf_evt_t rx_buf_b_evt,
    input  wire logic                      rx_dma_reset,
    input  wire logic                      tx_buffer_b_unloaded_event,
    input  wire logic                      tx_buffer_a_unloaded_event,
    input  wire logic                      i2c_nack_received_event,
    input  wire logic                      i2c_command_done_event,
    input  wire logic                      i2c_transmit_done_event,
    input  wire logic                      i2c_receive_done_event,
    input  wire logic                      transmit_underrun_event,
    input  wire logic                      receive_overrun_event,
    input  wire logic                      transmitter_idle_event,
    input  wire logic                      transmit_space_free_event,
    input  wire logic                      receive_data_available_event,
    output logic                           irq
);

    localparam int EW = scirq_pkg::EVT_W;

    // Index times four gives the byte address on the 32-bit bus
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction : byte_addr

    logic [12:0]   rx_buffer_a_first_error_offset;
    logic [12:0]   rx_buffer_b_first_error_offset;
    logic [EW-1:0] serial_two_irq_enable_q;
    logic [EW-1:0] serial_two_irq_pending_q;
    logic [EW-1:0] evt_vec;
    logic [EW-1:0] clr_vec;
    logic          access;
    logic          wr_en;
    logic          hit_a;
    logic          hit_b;
    logic          hit_pend;
    logic          hit_en;
    logic          mapped;
    logic          lo_lanes;

    // First-error loggers, one per receive buffer
    scirq_err_log u_log_a (
        .pclk      (pclk),
        .presetn   (presetn),
        .err_in    (rx_err_a),
        .buf_evt   (rx_buf_a_evt),
        .dma_reset (rx_dma_reset),
        .offset_q  (rx_buffer_a_first_error_offset)
    );

    scirq_err_log u_log_b (
        .pclk      (pclk),
        .presetn   (presetn),
        .err_in    (rx_err_b),
        .buf_evt   (rx_buf_b_evt),
        .dma_reset (rx_dma_reset),
        .offset_q  (rx_buffer_b_first_error_offset)
    );

    // Address decode; the slave answers in the second access cycle, after one wait state
    assign access   = psel && penable;
    assign hit_a    = (paddr == byte_addr(scirq_pkg::IDX_RX_ERR_A));
    assign hit_b    = (paddr == byte_addr(scirq_pkg::IDX_RX_ERR_B));
    assign hit_pend = (paddr == byte_addr(scirq_pkg::IDX_IRQ_PEND));
    assign hit_en   = (paddr == byte_addr(scirq_pkg::IDX_IRQ_ENABLE));
    assign mapped   = hit_a || hit_b || hit_pend || hit_en;
    assign lo_lanes = (pstrb[1:0] == 2'b11);
    // Writes need both low lanes, so a 13-bit field never splits
    assign wr_en    = access && !pready && pwrite && lo_lanes;

    // Event vector in the shared enable/pending layout
    always_comb begin
        evt_vec = '0;
        evt_vec[scirq_pkg::BIT_TX_B_UNLOADED] = tx_buffer_b_unloaded_event;
        evt_vec[scirq_pkg::BIT_TX_A_UNLOADED] = tx_buffer_a_unloaded_event;
        evt_vec[scirq_pkg::BIT_RX_B_UNLOADED] = rx_buf_b_evt.unload;
        evt_vec[scirq_pkg::BIT_RX_A_UNLOADED] = rx_buf_a_evt.unload;
        evt_vec[scirq_pkg::BIT_I2C_NACK]      = i2c_nack_received_event;
        evt_vec[scirq_pkg::BIT_I2C_CMD_DONE]  = i2c_command_done_event;
        evt_vec[scirq_pkg::BIT_I2C_TX_DONE]   = i2c_transmit_done_event;
        evt_vec[scirq_pkg::BIT_I2C_RX_DONE]   = i2c_receive_done_event;
        evt_vec[scirq_pkg::BIT_TX_UNDERRUN]   = transmit_underrun_event;
        evt_vec[scirq_pkg::BIT_RX_OVERRUN]    = receive_overrun_event;
        evt_vec[scirq_pkg::BIT_TX_IDLE]       = transmitter_idle_event;
        evt_vec[scirq_pkg::BIT_TX_FREE]       = transmit_space_free_event;
        evt_vec[scirq_pkg::BIT_RX_AVAILABLE]  = receive_data_available_event;
    end

    // Write-one-to-clear mask for the pending register
    assign clr_vec = (wr_en && hit_pend) ? pwdata[EW-1:0] : '0;

    // Enable register; bits 15..13 are not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_two_irq_enable_q <= scirq_pkg::RST_EVT;
        end else if (wr_en && hit_en) begin
            serial_two_irq_enable_q <= pwdata[EW-1:0];
        end
    end

    // Sticky pending flags; a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_two_irq_pending_q <= scirq_pkg::RST_EVT;
        end else begin
            serial_two_irq_pending_q <= (serial_two_irq_pending_q & ~clr_vec) | evt_vec;
        end
    end

    // Interrupt registered from the updated flag state, one cycle behind an event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((serial_two_irq_pending_q & ~clr_vec) | evt_vec)
                     & serial_two_irq_enable_q);
        end
    end

    // APB answer: one ready pulse per access after one wait state, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Read data captured with ready; upper bits always zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= scirq_pkg::RST_RDATA;
        end else if (access && !pready && !pwrite) begin
            prdata <= '0;
            if (hit_a) begin
                prdata[12:0] <= rx_buffer_a_first_error_offset;
            end else if (hit_b) begin
                prdata[12:0] <= rx_buffer_b_first_error_offset;
            end else if (hit_pend) begin
                prdata[EW-1:0] <= serial_two_irq_pending_q;
            end else if (hit_en) begin
                prdata[EW-1:0] <= serial_two_irq_enable_q;
            end
        end else begin
            prdata <= '0;
        end
    end

endmodule : scirq_top

`default_nettype wire
